/* File: rtl/emp_external_memory_port.sv */
// external memory port: internal request side to external memory pins
// Operation
// RULE1 - an 8-bit two-way data bus, bit 0 least significant, carries access data.
// RULE2 - between transfers the data lines keep their last level by weak keepers, not drive.
// RULE3 - during reset the data lines stay at the level they had before reset.
// RULE4 - a 12-bit address output, bit 0 least significant, names each access target.
// RULE5 - address outputs change only when a new external access starts. The code also clears them to ADDR_RST (12'h000) in reset.
// RULE6 - each chip select goes low when the internal address decodes to its region.
// RULE7 - the read strobe goes low only during external reads.
// RULE8 - the slave drives read data only while the read strobe is low.
// RULE9 - the read strobe stays high while reset is active.
// RULE10 - the write strobe goes low only during external writes, data valid meanwhile.
// RULE11 - read and write strobes never overlap and the chip select covers each strobe.
`timescale 1ns/10ps
module emp_external_memory_port (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [emp_pkg::IADDR_W-1:0] req_addr,
  input  wire logic [emp_pkg::DATA_W-1:0]  req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic                             rsp_error,
  output logic [emp_pkg::DATA_W-1:0]       rsp_rdata,
  input  wire logic [emp_pkg::DATA_W-1:0]  ext_data_bus_in,
  output logic [emp_pkg::DATA_W-1:0]       ext_data_bus_out,
  output logic                             ext_data_bus_oe,
  output logic [emp_pkg::ADDR_W-1:0]       ext_addr_bus,
  output logic                             region_select_a_n,
  output logic                             region_select_b_n,
  output logic                             ext_rd_strobe_n,
  output logic                             ext_wr_strobe_n
);
  import emp_pkg::*;

  // active-low select pair for an internal address, all ones when unmapped
  function automatic logic [SEL_W-1:0] region_decode(input logic [IADDR_W-1:0] a);
    logic [SEL_W-1:0] s;
    s = SEL_NONE;
    if (a[IADDR_W-1:TAG_LSB] == REGION_A_TAG) begin
      s[SEL_A_BIT] = 1'b0;
    end
    if (a[IADDR_W-1:TAG_LSB] == REGION_B_TAG) begin
      s[SEL_B_BIT] = 1'b0;
    end
    return s;
  endfunction

  logic                accept;
  logic                miss;
  logic                seq_busy;
  logic                seq_last;
  logic                seq_oe;
  logic                seq_rd_n;
  logic                seq_wr_n;
  logic [SEL_W-1:0]    req_sel;

  logic [ADDR_W-1:0]   addr_reg,   addr_next;
  logic [SEL_W-1:0]    sel_reg,    sel_next;
  logic                ready_reg,  ready_next;
  logic                rsp_reg,    rsp_next;
  logic                err_reg,    err_next;
  logic [DATA_W-1:0]   rdata_reg,  rdata_next;
  logic                write_reg,  write_next;
  logic [DATA_W-1:0]   keep_reg,   keep_next;
  logic [DATA_W-1:0]   sync1_reg,  sync2_reg, sync3_reg;
  logic [DATA_W-1:0]   filt_reg,   filt_next;

  assign req_sel = region_decode(req_addr);
  assign accept  = req_valid && ready_reg && (req_sel != SEL_NONE);
  assign miss    = req_valid && ready_reg && (req_sel == SEL_NONE);

  emp_strobe_seq u_seq (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .start       (accept),
    .start_write (req_write),
    .rd_n        (seq_rd_n),
    .wr_n        (seq_wr_n),
    .drive_en    (seq_oe),
    .busy        (seq_busy),
    .last        (seq_last)
  );

  // pin input filter: a bit moves once the second and third stages agree
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_reg <= DATA_RST;
      sync2_reg <= DATA_RST;
      sync3_reg <= DATA_RST;
      filt_reg  <= DATA_RST;
    end else begin
      sync1_reg <= ext_data_bus_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  always_comb begin
    addr_next  = addr_reg;
    sel_next   = sel_reg;
    // an idle sequencer reopens the request side unless a request is accepted in the same cycle
    ready_next = ready_reg | !seq_busy;
    rsp_next   = 1'b0;
    err_next   = miss;
    rdata_next = rdata_reg;
    write_next = write_reg;
    keep_next  = keep_reg;
    if (accept) begin
      addr_next  = req_addr[ADDR_W-1:0]; // RULE4 RULE5
      sel_next   = req_sel; // RULE6
      ready_next = 1'b0;
      write_next = req_write;
      if (req_write) begin
        keep_next = req_wdata; // RULE1 RULE10
      end
    end
    if (seq_last) begin
      // select rises only after the strobe has already gone high
      sel_next   = SEL_NONE; // RULE11
      ready_next = 1'b1;
      rsp_next   = 1'b1;
      if (!write_reg) begin
        // slave stopped driving when the strobe rose; filter lags four cycles
        rdata_next = filt_reg; // RULE8
        keep_next  = filt_reg; // RULE2
      end else begin
        rdata_next = keep_reg;
      end
    end
    if (!rstn) begin
      keep_next = keep_reg; // RULE3
    end
  end

  // keeper level has no reset so the lines keep their pre-reset level
  always_ff @(posedge sys_clk) begin
    keep_reg <= keep_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_reg  <= ADDR_RST;
      sel_reg   <= SEL_NONE;
      ready_reg <= 1'b0;
      rsp_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= DATA_RST;
      write_reg <= 1'b0;
    end else begin
      addr_reg  <= addr_next;
      sel_reg   <= sel_next;
      ready_reg <= ready_next;
      rsp_reg   <= rsp_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
    end
  end

  assign req_ready         = ready_reg;
  assign rsp_valid         = rsp_reg;
  assign rsp_error         = err_reg;
  assign rsp_rdata         = rdata_reg;
  assign ext_data_bus_out  = keep_reg; // RULE1 RULE2
  assign ext_data_bus_oe   = seq_oe;
  assign ext_addr_bus      = addr_reg;
  assign region_select_a_n = sel_reg[SEL_A_BIT];
  assign region_select_b_n = sel_reg[SEL_B_BIT];
  assign ext_rd_strobe_n   = seq_rd_n; // RULE9
  assign ext_wr_strobe_n   = seq_wr_n;

  property p_strobe_excl;
    @(posedge sys_clk) disable iff (!rstn) !(!ext_rd_strobe_n && !ext_wr_strobe_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("strobes overlap"); // RULE11

  property p_sel_covers;
    @(posedge sys_clk) disable iff (!rstn)
      (!ext_rd_strobe_n || !ext_wr_strobe_n) |-> (region_select_a_n != region_select_b_n);
  endproperty
  a_sel_covers: assert property (p_sel_covers) else $error("strobe without select"); // RULE11

  property p_addr_hold;
    @(posedge sys_clk) disable iff (!rstn) $changed(ext_addr_bus) |-> $past(accept);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while idle"); // RULE5

  property p_addr_load;
    @(posedge sys_clk) disable iff (!rstn)
      accept |=> ext_addr_bus == $past(req_addr[ADDR_W-1:0]);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded"); // RULE4

  property p_sel_decode;
    @(posedge sys_clk) disable iff (!rstn)
      accept |=> {region_select_b_n, region_select_a_n} == $past(req_sel);
  endproperty
  a_sel_decode: assert property (p_sel_decode) else $error("select decode wrong"); // RULE6

  property p_rd_len;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(ext_rd_strobe_n) |-> (!ext_rd_strobe_n && !write_reg) [*8] ##1 ext_rd_strobe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length or kind wrong"); // RULE7

  property p_wr_len;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(ext_wr_strobe_n) |-> (!ext_wr_strobe_n && write_reg && ext_data_bus_oe) [*8]
        ##1 ext_wr_strobe_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length or kind wrong"); // RULE10

  property p_rd_reset;
    @(posedge sys_clk) !rstn |=> ext_rd_strobe_n;
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("read strobe low after reset"); // RULE9

  property p_keep_reset;
    // case equality: the keeper level is unknown until the first access after power-up
    @(posedge sys_clk) !rstn |=> (ext_data_bus_out === $past(ext_data_bus_out));
  endproperty
  a_keep_reset: assert property (p_keep_reset) else $error("data level moved in reset"); // RULE3

  property p_idle_undriven;
    @(posedge sys_clk) disable iff (!rstn) !seq_busy |-> !ext_data_bus_oe;
  endproperty
  a_idle_undriven: assert property (p_idle_undriven) else $error("bus driven while idle"); // RULE2
endmodule

/* File: rtl/emp_pkg.sv */
// shared constants and types for the external memory port
package emp_pkg;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int IADDR_W = 16;
  localparam int SEL_W   = 2;
  localparam int CNT_W   = 4;

  // region tag sits in the top nibble of the internal address
  localparam int        TAG_LSB      = 12;
  localparam logic [3:0] REGION_A_TAG = 4'h1;
  localparam logic [3:0] REGION_B_TAG = 4'h2;

  // chip select field positions, active low
  localparam int SEL_A_BIT = 0;
  localparam int SEL_B_BIT = 1;
  localparam logic [SEL_W-1:0] SEL_NONE = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS     = 32;
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    EMP_IDLE   = 2'b00,
    EMP_SETUP  = 2'b01,
    EMP_STROBE = 2'b10,
    EMP_HOLD   = 2'b11
  } emp_state_t;
endpackage

/* File: rtl/emp_strobe_seq.sv */
// strobe sequencer: setup, strobe and hold phases of one external access
`timescale 1ns/10ps
module emp_strobe_seq (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic start_write,
  output logic      rd_n,
  output logic      wr_n,
  output logic      drive_en,
  output logic      busy,
  output logic      last
);
  import emp_pkg::*;

  emp_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg,   cnt_next;
  logic             write_reg, write_next;
  logic             rd_n_reg,  rd_n_next;
  logic             wr_n_reg,  wr_n_next;
  logic             oe_reg,    oe_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    write_next = write_reg;
    rd_n_next  = 1'b1;
    wr_n_next  = 1'b1;
    oe_next    = oe_reg;
    unique case (state_reg)
      EMP_IDLE: begin
        oe_next = 1'b0;
        if (start) begin
          state_next = EMP_SETUP;
          write_next = start_write;
          oe_next    = start_write; // RULE1
        end
      end
      EMP_SETUP: begin
        state_next = EMP_STROBE;
        cnt_next   = STROBE_CYC - 4'h1;
        // only one strobe ever falls, chosen by direction
        rd_n_next  = write_reg; // RULE7 RULE11
        wr_n_next  = ~write_reg; // RULE10 RULE11
      end
      EMP_STROBE: begin
        if (cnt_reg == 4'h0) begin
          state_next = EMP_HOLD;
        end else begin
          cnt_next  = cnt_reg - 4'h1;
          rd_n_next = write_reg;
          wr_n_next = ~write_reg;
        end
      end
      EMP_HOLD: begin
        // data stays driven one cycle past the write strobe for hold time
        state_next = EMP_IDLE;
        oe_next    = 1'b0; // RULE2
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= EMP_IDLE;
      cnt_reg   <= 4'h0;
      write_reg <= 1'b0;
      rd_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      write_reg <= write_next;
      rd_n_reg  <= rd_n_next;
      wr_n_reg  <= wr_n_next;
      oe_reg    <= oe_next;
    end
  end

  assign rd_n     = rd_n_reg;
  assign wr_n     = wr_n_reg;
  assign drive_en = oe_reg;
  assign busy     = (state_reg != EMP_IDLE);
  assign last     = (state_reg == EMP_HOLD);
endmodule

/* File: testbench/emp_external_memory_port_bench.sv */
// self-checking bench for the external memory port
`timescale 1ns/10ps
module emp_external_memory_port_bench;
  import emp_pkg::*;
  logic        sys_clk, rstn, req_valid, req_write, req_ready, rsp_valid, rsp_error;
  logic [15:0] req_addr;
  logic [7:0]  req_wdata, rsp_rdata, pin, d_out, m_data;
  logic        d_oe, m_en, rd_n, wr_n, sa_n, sb_n;
  logic [11:0] addr;
  int          miscompares, checks_done, i;
  logic [32:0] rows [6] = '{{1'b1, 16'h1005, 8'hA5, 8'hA5}, {1'b1, 16'h2005, 8'h3C, 8'h3C},
    {1'b1, 16'h1FFF, 8'h80, 8'h80}, {1'b0, 16'h1005, 8'h00, 8'hA5},
    {1'b0, 16'h2005, 8'h00, 8'h3C}, {1'b0, 16'h1FFF, 8'h00, 8'h80}};
  // keepers hold the last level when neither side drives
  assign pin = d_oe ? d_out : (m_en ? m_data : d_out);
  emp_external_memory_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .ext_data_bus_in(pin), .ext_data_bus_out(d_out),
    .ext_data_bus_oe(d_oe), .ext_addr_bus(addr), .region_select_a_n(sa_n),
    .region_select_b_n(sb_n), .ext_rd_strobe_n(rd_n), .ext_wr_strobe_n(wr_n));
  emp_mem_model i_mem (.sys_clk(sys_clk), .region_select_a_n(sa_n),
    .region_select_b_n(sb_n), .ext_rd_strobe_n(rd_n), .ext_wr_strobe_n(wr_n),
    .ext_addr_bus(addr), .pin_level(pin), .drv_data(m_data), .drv_en(m_en));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic give_up();
    miscompares++;
    conclude();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) give_up();
  endtask
  // one access; checks pins mid-strobe and the exact answer cycle
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int n;
    wait_ready();
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 20) begin
      if (n == 5) begin
        chk(rd_n, w);
        chk(wr_n, !w);
        chk(rd_n & wr_n, 1'b0);
        chk(sa_n, a[15:12] != 4'h1);
        chk(sb_n, a[15:12] != 4'h2);
        chk(addr, a[11:0]);
        chk(req_ready, 1'b0);
        chk(d_oe, w);
        if (w) chk(d_out, d);
      end
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20) give_up();
    chk(n, 11);
    chk(rsp_rdata, e);
  endtask
  initial begin
    miscompares = 0;
    checks_done = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    repeat (6) @(negedge sys_clk);
    chk({rd_n, wr_n, sa_n, sb_n}, 4'hF);
    rstn = 1'b1;
    for (i = 0; i < 6; i++) begin
      acc(rows[i][32], rows[i][31:16], rows[i][15:8], rows[i][7:0]);
    end
    $display("table accesses done");
    repeat (5) @(negedge sys_clk);
    chk(d_oe, 1'b0);
    chk(d_out, 8'h80);
    chk(addr, 12'hFFF);
    wait_ready();
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr = 16'h3123;
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk(rsp_error, 1'b1);
    chk({rd_n, wr_n, sa_n, sb_n}, 4'hF);
    chk(addr, 12'hFFF);
    $display("unmapped access done");
    @(negedge sys_clk);
    wait_ready();
    req_valid = 1'b1;
    req_addr = 16'h1005;
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(rd_n, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(rd_n, 1'b1);
    chk(d_out, 8'h80);
    chk(d_oe, 1'b0);
    rstn = 1'b1;
    acc(1'b0, 16'h2005, 8'h00, 8'h3C);
    $display("reset in mid read done");
    conclude();
  end
endmodule

/* File: testbench/emp_mem_model.sv */
// external byte memory answering the port's strobes
`timescale 1ns/10ps
module emp_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        region_select_a_n,
  input  wire logic        region_select_b_n,
  input  wire logic        ext_rd_strobe_n,
  input  wire logic        ext_wr_strobe_n,
  input  wire logic [11:0] ext_addr_bus,
  input  wire logic [7:0]  pin_level,
  output logic [7:0]       drv_data,
  output logic             drv_en
);
  logic [7:0]  mem [0:8191];
  logic [12:0] idx;
  // region b sits in the upper half, so a decode slip reads the wrong byte
  assign idx = {region_select_a_n, ext_addr_bus};
  always_ff @(posedge sys_clk) begin
    if (!ext_wr_strobe_n && !(region_select_a_n && region_select_b_n)) begin
      mem[idx] <= pin_level;
    end
  end
  // drive only while the read strobe is low, else let the keepers hold
  assign drv_en   = !ext_rd_strobe_n;
  assign drv_data = drv_en ? mem[idx] : 8'h00;
endmodule
